// file: dma_pkg.sv
// Shared constants and types for the ISA DMA controller
package dma_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] TIMING_BUF_CTRL_OFS = 8'h65;
    localparam logic [7:0] TIMING_BUF_CTRL_RST = 8'h00;
    localparam int BUF_EN_BIT = 7;
    localparam int FAST_CH_LSB = 0;
    localparam int NUM_CH = 8;
    localparam int CASCADE_CH = 4;
    localparam int BUF_BYTES = 16;

    // ****************************************
    // Timing in SYSCLKs, request latency and clock period in ns
    // ****************************************
    localparam int COMPAT_CYCLE = 8;
    localparam int FAST_CYCLE = 3;
    localparam int VERIFY_FIRST = 9;
    localparam int VERIFY_MORE = 8;
    localparam int DREQ_DELAY = 8;
    localparam int DREQ_LATENCY_NS = 1000;
    localparam int SYSCLK_NS = 8;
    localparam int DREQ_LATENCY_CYC = (DREQ_LATENCY_NS + SYSCLK_NS - 1) / SYSCLK_NS;

    localparam logic [15:0] COUNT_WRAP = 16'hFFFF;
    localparam logic [7:0] ADDR_16M_PAGE_LIMIT = 8'hFF;
    localparam logic [3:0] LOW_MEM_NIBBLE = 4'h0;

    typedef enum logic [1:0] {MODE_DEMAND, MODE_SINGLE, MODE_BLOCK, MODE_CASCADE} xfer_mode_t;
    typedef enum logic [1:0] {TYPE_VERIFY, TYPE_WRITE, TYPE_READ, TYPE_ILLEGAL} xfer_type_t;
endpackage

// file: dma_buffer_mem.sv
// Post-write and prefetch byte buffer with registered read data
`timescale 1ns/1ps
module dma_buffer_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i, // Clock
    input wire logic wr_en_i, // Write strobe
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i, // Write index
    input wire logic [WIDTH-1:0] wr_data_i, // Write data
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i, // Read index
    output logic [WIDTH-1:0] rd_data_o // Registered read data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
        begin
            $error("dma_buffer_mem: bad geometry");
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (wr_en_i)
        begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule

// file: isa_dma_controller.sv
// Seven-channel cascaded ISA DMA controller core
`timescale 1ns/1ps
module isa_dma_controller #(
    parameter int BUF_DEPTH = dma_pkg::BUF_BYTES
) (
    input wire logic core_clk_i, // SYSCLK-rate clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic [7:0] dreq_i, // Hardware requests from pins
    output logic [7:0] dma_grant_ack_n_o, // Acknowledges, active low
    input wire logic cfg_wr_i, // Register write strobe
    input wire logic [7:0] cfg_addr_i, // Register index
    input wire logic [7:0] cfg_wdata_i, // Register write data
    output logic [7:0] cfg_rdata_o, // Register read data
    input wire logic ch_prog_i, // Program channel strobe
    input wire logic [2:0] ch_sel_i, // Channel being programmed
    input wire logic [15:0] ch_addr_i, // Base address
    input wire logic [7:0] ch_page_i, // Base page
    input wire logic [15:0] ch_count_i, // Base count
    input wire logic [1:0] ch_mode_i, // Transfer mode
    input wire logic [1:0] ch_type_i, // Transfer type
    input wire logic ch_dec_i, // Address decrements
    input wire logic ch_auto_i, // Autoinitialise
    input wire logic [7:0] sw_req_wr_i, // Software request set, one-cycle
    input wire logic [7:0] mask_i, // Channel masks
    input wire logic isa_mem_i, // Target memory is ISA resident
    input wire logic isa_busy_i, // ISA cycle pending
    input wire logic pci_hold_ack_i, // North bridge grant
    input wire logic pci_done_i, // PCI data movement finished
    input wire logic pci_isa_cycle_i, // PCI cycle aimed at ISA
    input wire logic [7:0] io_data_i, // Peripheral data for writes
    output logic pci_hold_request_n_o, // PCI hold, active low
    output logic pci_retry_o, // Retry answer to PCI
    output logic [23:0] mem_addr_o, // DMA memory address
    output logic addr_oe_o, // Address and byte-high driven
    output logic byte_high_enable_n_o, // Byte-high enable
    output logic strobe_oe_o, // Command strobes driven
    output logic isa_mem_read_n_o, // Memory read
    output logic isa_mem_write_n_o, // Memory write
    output logic low_mem_read_n_o, // Low memory read
    output logic low_mem_write_n_o, // Low memory write
    output logic isa_io_read_n_o, // I/O read
    output logic isa_io_write_n_o, // I/O write
    output logic aen_o, // Address enable
    output logic bale_o, // Address latch enable
    output logic terminal_count_o, // Terminal count pulse
    output logic [7:0] buf_rdata_o // Buffer read data
);
    localparam int PW = $clog2(BUF_DEPTH);

    initial
    begin
        if (BUF_DEPTH != dma_pkg::BUF_BYTES)
        begin
            $error("isa_dma_controller: buffer depth must be 16");
        end
    end

    // ****************************************
    // Reset and pin synchronisers
    // ****************************************
    logic rst_meta_reg, rst_n_reg;
    logic [7:0] dreq_meta_reg, dreq_sync_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            dreq_meta_reg <= 8'h00;
            dreq_sync_reg <= 8'h00;
        end
        else
        begin
            dreq_meta_reg <= dreq_i;
            dreq_sync_reg <= dreq_meta_reg;
        end
    end

    // ****************************************
    // Timing and buffer control register
    // ****************************************
    logic [7:0] ctrl_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctrl_reg <= dma_pkg::TIMING_BUF_CTRL_RST;
        end
        else if (cfg_wr_i && cfg_addr_i == dma_pkg::TIMING_BUF_CTRL_OFS)
        begin
            ctrl_reg <= cfg_wdata_i;
        end
    end
    wire logic buf_en = ctrl_reg[dma_pkg::BUF_EN_BIT];
    wire logic fast_dma_select = ctrl_reg[dma_pkg::FAST_CH_LSB];

    // ****************************************
    // Channel state and request delay
    // ****************************************
    logic [15:0] cur_addr_reg [8], base_addr_reg [8], cur_cnt_reg [8], base_cnt_reg [8];
    logic [7:0] cur_page_reg [8], base_page_reg [8];
    dma_pkg::xfer_mode_t mode_reg [8];
    dma_pkg::xfer_type_t type_reg [8];
    logic [7:0] dec_reg, auto_reg, sw_req_reg;
    logic [dma_pkg::DREQ_DELAY-1:0] dly_reg [8];
    logic [7:0] eff_req;
    logic [2:0] act_ch_reg;
    logic step_pulse, tc_hit;

    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_XFER, ST_MASTER} state_t;
    state_t state_reg;

    assign tc_hit = (cur_cnt_reg[act_ch_reg] == 16'h0000);

    genvar g;
    generate
        for (g = 0; g < dma_pkg::NUM_CH; g++)
        begin : g_ch
            always_ff @(posedge core_clk_i or negedge rst_n_reg)
            begin
                if (!rst_n_reg)
                begin
                    dly_reg[g] <= '0;
                end
                else
                begin
                    dly_reg[g] <= {dly_reg[g][dma_pkg::DREQ_DELAY-2:0], dreq_sync_reg[g]};
                end
            end
            // Software and fast timing see the request at once
            assign eff_req[g] = !mask_i[g] && (sw_req_reg[g] ||
                (fast_dma_select ? dreq_sync_reg[g] : (dreq_sync_reg[g] && dly_reg[g][dma_pkg::DREQ_DELAY-1])));
            always_ff @(posedge core_clk_i or negedge rst_n_reg)
            begin
                if (!rst_n_reg)
                begin
                    mode_reg[g] <= (g == dma_pkg::CASCADE_CH) ? dma_pkg::MODE_CASCADE : dma_pkg::MODE_SINGLE;
                    type_reg[g] <= dma_pkg::TYPE_VERIFY;
                    dec_reg[g] <= 1'b0;
                    auto_reg[g] <= 1'b0;
                    sw_req_reg[g] <= 1'b0;
                    cur_addr_reg[g] <= 16'h0000;
                    base_addr_reg[g] <= 16'h0000;
                    cur_cnt_reg[g] <= 16'h0000;
                    base_cnt_reg[g] <= 16'h0000;
                    cur_page_reg[g] <= 8'h00;
                    base_page_reg[g] <= 8'h00;
                end
                else if (ch_prog_i && ch_sel_i == 3'(g))
                begin
                    mode_reg[g] <= dma_pkg::xfer_mode_t'(ch_mode_i);
                    type_reg[g] <= (ch_type_i == 2'h3) ? dma_pkg::TYPE_VERIFY : dma_pkg::xfer_type_t'(ch_type_i);
                    dec_reg[g] <= ch_dec_i;
                    auto_reg[g] <= ch_auto_i;
                    cur_addr_reg[g] <= ch_addr_i;
                    base_addr_reg[g] <= ch_addr_i;
                    cur_cnt_reg[g] <= ch_count_i;
                    base_cnt_reg[g] <= ch_count_i;
                    cur_page_reg[g] <= ch_page_i;
                    base_page_reg[g] <= ch_page_i;
                end
                else
                begin
                    // Set wins over the end-of-service clear
                    if (sw_req_wr_i[g])
                    begin
                        sw_req_reg[g] <= 1'b1;
                    end
                    else if (step_pulse && act_ch_reg == 3'(g) && tc_hit)
                    begin
                        sw_req_reg[g] <= 1'b0;
                    end
                    if (step_pulse && act_ch_reg == 3'(g))
                    begin
                        if (tc_hit && auto_reg[g])
                        begin
                            cur_addr_reg[g] <= base_addr_reg[g];
                            cur_cnt_reg[g] <= base_cnt_reg[g];
                            cur_page_reg[g] <= base_page_reg[g];
                        end
                        else
                        begin
                            // Page never changes; address wraps inside 64K
                            cur_cnt_reg[g] <= cur_cnt_reg[g] - 16'h0001;
                            cur_addr_reg[g] <= dec_reg[g] ? cur_addr_reg[g] - 16'h0001 : cur_addr_reg[g] + 16'h0001;
                        end
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Arbiter, fixed priority
    // ****************************************
    logic [2:0] win_ch;
    logic win_any;
    always_comb
    begin
        win_ch = 3'h0;
        win_any = 1'b0;
        for (int i = dma_pkg::NUM_CH - 1; i >= 0; i--)
        begin
            if (eff_req[i] && (i != dma_pkg::CASCADE_CH))
            begin
                win_ch = 3'(i);
                win_any = 1'b1;
            end
        end
    end

    // ****************************************
    // Service sequencer
    // ****************************************
    logic [3:0] cyc_cnt_reg;
    logic first_reg, tc_reg, retry_reg;
    logic [PW:0] fill_reg;
    dma_pkg::xfer_mode_t cm;
    dma_pkg::xfer_type_t ct;
    logic [3:0] cyc_len;
    logic need_pci;
    assign cm = mode_reg[act_ch_reg];
    assign ct = type_reg[act_ch_reg];
    // Verify first beat spans nine clocks, repeats eight
    assign cyc_len = (ct == dma_pkg::TYPE_VERIFY) ? (first_reg ? 4'(dma_pkg::VERIFY_FIRST) : 4'(dma_pkg::VERIFY_MORE))
                   : (fast_dma_select ? 4'(dma_pkg::FAST_CYCLE) : 4'(dma_pkg::COMPAT_CYCLE));
    assign step_pulse = (state_reg == ST_XFER) && (cyc_cnt_reg == cyc_len - 4'h1);
    // Buffered PCI movement: read prefetch at start or empty, write on full
    assign need_pci = !isa_mem_i && (ct != dma_pkg::TYPE_VERIFY) &&
        (!buf_en || (ct == dma_pkg::TYPE_READ ? fill_reg == '0 : fill_reg == (PW+1)'(BUF_DEPTH)));

    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= ST_IDLE;
            act_ch_reg <= 3'h0;
            cyc_cnt_reg <= 4'h0;
            first_reg <= 1'b1;
            tc_reg <= 1'b0;
            fill_reg <= '0;
        end
        else
        begin
            tc_reg <= step_pulse && tc_hit;
            unique case (state_reg)
                ST_IDLE:
                begin
                    first_reg <= 1'b1;
                    cyc_cnt_reg <= 4'h0;
                    if (win_any && !(buf_en && isa_busy_i))
                    begin
                        act_ch_reg <= win_ch;
                        if (mode_reg[win_ch] == dma_pkg::MODE_CASCADE)
                        begin
                            state_reg <= ST_MASTER;
                        end
                        else if (mode_reg[win_ch] == dma_pkg::MODE_BLOCK && fast_dma_select)
                        begin
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            state_reg <= buf_en ? ST_XFER : ST_HOLD;
                        end
                    end
                end
                ST_HOLD:
                begin
                    if (pci_hold_ack_i || isa_mem_i || ct == dma_pkg::TYPE_VERIFY)
                    begin
                        state_reg <= ST_XFER;
                    end
                end
                ST_XFER:
                begin
                    if (buf_en && need_pci && !pci_done_i)
                    begin
                        cyc_cnt_reg <= cyc_cnt_reg; // Stall until PCI side moves data
                    end
                    else if (buf_en && need_pci)
                    begin
                        fill_reg <= (ct == dma_pkg::TYPE_READ) ? (PW+1)'(BUF_DEPTH) : '0;
                    end
                    else if (step_pulse)
                    begin
                        cyc_cnt_reg <= 4'h0;
                        first_reg <= 1'b0;
                        if (buf_en)
                        begin
                            fill_reg <= (ct == dma_pkg::TYPE_READ) ? fill_reg - 1'b1 : fill_reg + 1'b1;
                        end
                        // Single ends per beat; demand ends on request drop
                        if (tc_hit || cm == dma_pkg::MODE_SINGLE ||
                            (cm == dma_pkg::MODE_DEMAND && !dreq_sync_reg[act_ch_reg] && !sw_req_reg[act_ch_reg]))
                        begin
                            state_reg <= ST_IDLE;
                            fill_reg <= '0; // Fill count cleared at end; posted writes and prefetched reads are both discarded
                        end
                    end
                    else
                    begin
                        cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
                    end
                end
                ST_MASTER:
                begin
                    if (!dreq_sync_reg[act_ch_reg])
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            retry_reg <= 1'b0;
        end
        else
        begin
            retry_reg <= buf_en && (state_reg != ST_IDLE) && pci_isa_cycle_i;
        end
    end

    // ****************************************
    // Buffer storage
    // ****************************************
    dma_buffer_mem #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
        .core_clk_i(core_clk_i),
        .wr_en_i(step_pulse && buf_en && ct == dma_pkg::TYPE_WRITE),
        .wr_addr_i(fill_reg[PW-1:0]),
        .wr_data_i(io_data_i),
        .rd_addr_i(fill_reg[PW-1:0]),
        .rd_data_o(buf_rdata_o)
    );

    // ****************************************
    // Pin drive
    // ****************************************
    logic xfer, mem_ok, low_ok, act_strb;
    assign xfer = (state_reg == ST_XFER);
    assign mem_addr_o = {cur_page_reg[act_ch_reg], cur_addr_reg[act_ch_reg]};
    // Without an upper address line the 24-bit space stays below 16M
    assign mem_ok = mem_addr_o[23:16] <= dma_pkg::ADDR_16M_PAGE_LIMIT;
    assign low_ok = mem_addr_o[23:20] == dma_pkg::LOW_MEM_NIBBLE;
    assign act_strb = xfer && (ct != dma_pkg::TYPE_VERIFY);
    assign addr_oe_o = xfer;
    assign strobe_oe_o = xfer;
    assign byte_high_enable_n_o = !(xfer && act_ch_reg > 3'(dma_pkg::CASCADE_CH));
    assign isa_mem_write_n_o = !(act_strb && ct == dma_pkg::TYPE_WRITE && mem_ok);
    assign isa_mem_read_n_o = !(act_strb && ct == dma_pkg::TYPE_READ && mem_ok);
    assign low_mem_write_n_o = !(act_strb && ct == dma_pkg::TYPE_WRITE && low_ok);
    assign low_mem_read_n_o = !(act_strb && ct == dma_pkg::TYPE_READ && low_ok);
    assign isa_io_read_n_o = !(act_strb && ct == dma_pkg::TYPE_WRITE);
    assign isa_io_write_n_o = !(act_strb && ct == dma_pkg::TYPE_READ);
    assign aen_o = xfer;
    assign bale_o = xfer || (state_reg == ST_MASTER);
    assign terminal_count_o = tc_reg;
    assign pci_retry_o = retry_reg;
    assign pci_hold_request_n_o = !((state_reg == ST_HOLD) || (xfer && buf_en && need_pci));
    assign cfg_rdata_o = (cfg_addr_i == dma_pkg::TIMING_BUF_CTRL_OFS) ? ctrl_reg : 8'h00;

    always_comb
    begin
        dma_grant_ack_n_o = 8'hFF;
        if (xfer || state_reg == ST_MASTER)
        begin
            dma_grant_ack_n_o[act_ch_reg] = 1'b0;
        end
    end
endmodule

// file: dma_port_monitor.sv
// Concurrent port checks for the ISA DMA controller
`timescale 1ns/1ps
module dma_port_monitor (
    input wire logic core_clk_i, // Clock
    input wire logic nrst_i, // Reset, low
    input wire logic [7:0] dma_grant_ack_n_o, // Acks
    input wire logic [7:0] cfg_addr_i, // Index
    input wire logic [7:0] cfg_rdata_o, // Read data
    input wire logic [23:0] mem_addr_o, // Address
    input wire logic addr_oe_o, // Address driven
    input wire logic strobe_oe_o, // Strobes driven
    input wire logic low_mem_read_n_o, // Low read
    input wire logic isa_io_read_n_o, // I/O read
    input wire logic isa_io_write_n_o, // I/O write
    input wire logic aen_o, // Address enable
    input wire logic bale_o, // Latch enable
    input wire logic terminal_count_o // Terminal count
);
    // ****************************************
    // Port relations
    // ****************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    a_one_grant: assert property ($onehot0(~dma_grant_ack_n_o)) else $error("two acks");
    a_chain_ack: assert property (dma_grant_ack_n_o[4]) else $error("chain channel acked");
    a_xfer_bale: assert property (aen_o |-> bale_o && !(&dma_grant_ack_n_o)) else $error("aen alone");
    a_master_float: assert property (bale_o && !aen_o |-> !addr_oe_o && !strobe_oe_o) else $error("float");
    a_strobe_xfer: assert property (strobe_oe_o |-> aen_o) else $error("strobes outside xfer");
    a_low_mem: assert property (!low_mem_read_n_o |-> mem_addr_o[23:20] == 4'h0) else $error("low read");
    a_io_pair: assert property (!(!isa_io_read_n_o && !isa_io_write_n_o)) else $error("io both");
    a_tc_pulse: assert property (terminal_count_o |=> !terminal_count_o) else $error("tc long");
    a_beat_min: assert property ($fell(&dma_grant_ack_n_o) |-> !(&dma_grant_ack_n_o) [*3]) else $error("short");
    a_reg_hole: assert property (cfg_addr_i != 8'h65 |-> cfg_rdata_o == 8'h00) else $error("unmapped read");
endmodule

// file: north_bridge_model.sv
// North bridge model answering the PCI hold handshake
`timescale 1ns/1ps
module north_bridge_model (
    input wire logic core_clk_i, // Clock
    input wire logic nrst_i, // Reset, low
    input wire logic pci_hold_request_n_o, // Hold request
    output logic pci_hold_ack_i, // Grant
    output logic pci_done_i // Movement done
);
    // ****************************************
    // Grant after a random pause
    // ****************************************
    logic wait_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wait_reg <= 1'b0;
            pci_hold_ack_i <= 1'b0;
            pci_done_i <= 1'b0;
        end
        else if (pci_hold_request_n_o)
        begin
            wait_reg <= 1'($urandom);
            pci_hold_ack_i <= 1'b0;
            pci_done_i <= 1'b0;
        end
        else if (wait_reg)
            wait_reg <= 1'b0;
        else
        begin
            pci_hold_ack_i <= 1'b1;
            // Done only after grant was seen, never in the same cycle
            pci_done_i <= pci_hold_ack_i;
        end
    end
endmodule

// file: tb_top.sv
// Self-checking bench for the ISA DMA controller
`timescale 1ns/1ps
module tb_top;
    // ****************************************
    // Stimulus, checks and verdict
    // ****************************************
    logic core_clk_i = 1'b0, nrst_i = 1'b0, cfg_wr_i = 1'b0, ch_prog_i = 1'b0, ch_dec_i = 1'b0, ch_auto_i = 1'b0;
    logic isa_mem_i = 1'b0, isa_busy_i = 1'b0, pci_isa_cycle_i = 1'b0, pci_hold_ack_i, pci_done_i, fast = 1'b0;
    logic [7:0] dreq_i = 8'h00, cfg_addr_i = 8'h00, cfg_wdata_i = 8'h00, sw_req_wr_i = 8'h00, mask_i = 8'h00;
    logic [7:0] ch_page_i = 8'h00, io_data_i = 8'h00, dma_grant_ack_n_o, cfg_rdata_o;
    logic [15:0] ch_addr_i = 16'h0000, ch_count_i = 16'h0000;
    logic [2:0] ch_sel_i = 3'h0;
    logic [1:0] ch_mode_i = 2'h0, ch_type_i = 2'h0;
    logic [23:0] mem_addr_o, base;
    logic pci_hold_request_n_o, pci_retry_o, addr_oe_o, strobe_oe_o, isa_io_read_n_o, isa_io_write_n_o;
    logic aen_o, bale_o, terminal_count_o, tc_seen = 1'b0, retry_seen = 1'b0;
    logic byte_high_enable_n_o, isa_mem_read_n_o, isa_mem_write_n_o, low_mem_read_n_o, low_mem_write_n_o;
    int error_cnt = 0, checks_done = 0, lat, k;
    isa_dma_controller isa_dma_controller_inst (.core_clk_i, .nrst_i, .dreq_i, .dma_grant_ack_n_o, .cfg_wr_i,
        .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .ch_prog_i, .ch_sel_i, .ch_addr_i, .ch_page_i, .ch_count_i,
        .ch_mode_i, .ch_type_i, .ch_dec_i, .ch_auto_i, .sw_req_wr_i, .mask_i, .isa_mem_i, .isa_busy_i,
        .pci_hold_ack_i, .pci_done_i, .pci_isa_cycle_i, .io_data_i, .pci_hold_request_n_o, .pci_retry_o,
        .mem_addr_o, .addr_oe_o, .byte_high_enable_n_o, .strobe_oe_o, .isa_mem_read_n_o, .isa_mem_write_n_o,
        .low_mem_read_n_o, .low_mem_write_n_o, .isa_io_read_n_o, .isa_io_write_n_o, .aen_o, .bale_o,
        .terminal_count_o, .buf_rdata_o());
    north_bridge_model north_bridge_model_inst (.core_clk_i, .nrst_i, .pci_hold_request_n_o, .pci_hold_ack_i,
        .pci_done_i);
    always #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        io_data_i <= 8'($urandom);
        tc_seen <= (tc_seen && !ch_prog_i) || (terminal_count_o === 1'b1);
        retry_seen <= retry_seen | (pci_retry_o === 1'b1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cfg_write(input logic [7:0] d);
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= dma_pkg::TIMING_BUF_CTRL_OFS;
        cfg_wdata_i <= d;
        fast <= d[0];
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b0;
        @(negedge core_clk_i);
        check(cfg_rdata_o, d);
    endtask
    task automatic prog(input int ch, input logic [1:0] md, input logic [1:0] ty, input logic [15:0] cnt);
        base = 24'($urandom) & ($urandom % 2 ? 24'h0FFFFE : 24'hFFFFFE);
        @(posedge core_clk_i);
        {ch_prog_i, ch_sel_i, ch_mode_i, ch_type_i, ch_count_i} <= {1'b1, 3'(ch), md, ty, cnt};
        {ch_page_i, ch_addr_i, ch_dec_i} <= {base, 1'b0};
        @(posedge core_clk_i);
        ch_prog_i <= 1'b0;
    endtask
    task automatic settle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 400 && quiet < 24; i++)
        begin
            @(negedge core_clk_i);
            quiet = (&dma_grant_ack_n_o === 1'b1) ? quiet + 1 : 0;
        end
        check(quiet, 24);
        if (quiet < 24)
            report_and_stop();
    endtask
    // Length 0 means the request must be refused, -1 means the beat may stall
    task automatic serve(input int ch, input logic [1:0] md, input logic [1:0] ty, input logic [15:0] cnt,
        input logic sw, input int len);
        int n;
        logic [1:0] e;
        prog(ch, md, ty, cnt);
        @(posedge core_clk_i);
        if (sw)
            sw_req_wr_i <= 8'(1 << ch);
        else
            dreq_i[ch] <= 1'b1;
        @(posedge core_clk_i);
        sw_req_wr_i <= 8'h00;
        for (lat = 1; lat < 200 && dma_grant_ack_n_o[ch] !== 1'b0; lat++)
            @(negedge core_clk_i);
        if (len == 0)
        begin
            check(dma_grant_ack_n_o[ch], 1'b1);
            @(posedge core_clk_i);
            dreq_i[ch] <= 1'b0;
            return;
        end
        check(dma_grant_ack_n_o[ch], 1'b0);
        if (lat >= 200)
            report_and_stop();
        check(lat >= 10, !(sw || fast));
        check(mem_addr_o, base);
        check({aen_o, bale_o}, {md != 2'h3, 1'b1});
        e = ty == 2'h1 ? 2'b01 : ty == 2'h2 ? 2'b10 : 2'b11;
        check({isa_io_read_n_o, isa_io_write_n_o, isa_mem_write_n_o, isa_mem_read_n_o}, {e, e});
        e = base[23:20] == 4'h0 ? e : 2'b11;
        check({low_mem_write_n_o, low_mem_read_n_o, byte_high_enable_n_o}, {e, ch < 4 || md == 2'h3});
        @(posedge core_clk_i);
        dreq_i[ch] <= 1'b0;
        for (n = 0; n < 60 && dma_grant_ack_n_o[ch] === 1'b0; n++)
            @(negedge core_clk_i);
        if (len > 0)
            check(n, len);
        settle();
        check(tc_seen, md == 2'h2 || cnt == 16'h0000);
    endtask
    initial
    begin
        void'($urandom(32'h9442));
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        cfg_addr_i <= dma_pkg::TIMING_BUF_CTRL_OFS;
        @(negedge core_clk_i);
        check(cfg_rdata_o, dma_pkg::TIMING_BUF_CTRL_RST);
        for (k = 0; k < 8; k++)
        begin
            lat = (k % 7) + (k % 7 > 3);
            serve(lat, 2'($urandom % 2), 2'(k), k % 3 == 0 || k == 7 ? 16'h0000 : 16'h0002 + 16'($urandom % 64), k == 7,
                k % 4 == 0 || k % 4 == 3 ? 9 : 8);
        end
        serve(2, dma_pkg::MODE_BLOCK, dma_pkg::TYPE_WRITE, 16'h0001, 1'b0, 16);
        serve(6, dma_pkg::MODE_BLOCK, dma_pkg::TYPE_VERIFY, 16'h0001, 1'b0, 17);
        serve(4, dma_pkg::MODE_CASCADE, dma_pkg::TYPE_VERIFY, 16'h0000, 1'b0, 0);
        serve(5, dma_pkg::MODE_CASCADE, dma_pkg::TYPE_VERIFY, 16'h0001, 1'b0, 4);
        mask_i <= 8'h20;
        serve(5, dma_pkg::MODE_SINGLE, dma_pkg::TYPE_READ, 16'h0003, 1'b0, 0);
        mask_i <= 8'h00;
        prog(5, dma_pkg::MODE_SINGLE, dma_pkg::TYPE_READ, 16'h0005);
        prog(0, dma_pkg::MODE_SINGLE, dma_pkg::TYPE_WRITE, 16'h0005);
        @(posedge core_clk_i);
        dreq_i <= 8'h21;
        for (lat = 0; lat < 200 && dma_grant_ack_n_o[0] !== 1'b0; lat++)
            @(negedge core_clk_i);
        check(dma_grant_ack_n_o[5:0], 6'h3E);
        @(posedge core_clk_i);
        dreq_i <= 8'h00;
        settle();
        cfg_write(8'h01);
        serve(3, dma_pkg::MODE_SINGLE, dma_pkg::TYPE_WRITE, 16'h0004, 1'b0, 3);
        serve(7, dma_pkg::MODE_BLOCK, dma_pkg::TYPE_READ, 16'h0004, 1'b0, 0);
        cfg_write(8'h80);
        pci_isa_cycle_i <= 1'b1;
        serve(1, dma_pkg::MODE_SINGLE, dma_pkg::TYPE_WRITE, 16'h0006, 1'b0, -1);
        check(retry_seen, 1'b1);
        report_and_stop();
    end
endmodule
bind isa_dma_controller dma_port_monitor dma_port_monitor_inst (.core_clk_i, .nrst_i, .dma_grant_ack_n_o,
    .cfg_addr_i, .cfg_rdata_o, .mem_addr_o, .addr_oe_o, .strobe_oe_o, .low_mem_read_n_o, .isa_io_read_n_o,
    .isa_io_write_n_o, .aen_o, .bale_o, .terminal_count_o);
